// ==== pkg/afss_pkg.sv ====
// Purpose: Shared constants and types for the analog frequency source selector
// Assumes: One core clock, register port with one-cycle read latency
// Notes:   Configuration codes are stored as written; see decode in afss_top
// Function
// - One filter setting 1..30 for voltage, current and bipolar inputs
// - Modes 00/03: select picks voltage or current
// - Mode 01 adds bipolar trim to voltage/current
// - Mode 02 trims; no reverse with alt 02..04 unless bipolar is main
// - Alt settings 02..04: select high picks keypad
// - Negative bipolar value commands reverse rotation
// - Unmapped select ignores alternate-input setting
// - Unmapped: bipolar alone or voltage plus current
// - Unmapped mode 01 keeps bipolar input unipolar
// - Trim adds bipolar offset; bipolar main alone
// - Select change re-evaluates source after the two-stage synchroniser
// - Full-scale point maps voltage to maximum
// - Analog command only when source is terminals
package afss_pkg;

  // ==========================================================
  // Register map
  localparam int           ADDR_W         = 8;
  localparam logic [7:0]   REG_CFG        = 8'h00;
  localparam logic [7:0]   REG_FSCALE     = 8'h04;
  localparam logic [7:0]   REG_STATUS     = 8'h08;

  // ==========================================================
  // Configuration field layout
  localparam int           CFG_DEPTH_LSB  = 0;
  localparam int           CFG_TRIM_LSB   = 8;
  localparam int           CFG_ALT_LSB    = 12;
  localparam int           CFG_MAPPED_BIT = 16;
  localparam int           CFG_FSRC_LSB   = 20;
  localparam int           STAT_REV_BIT   = 16;
  localparam int           STAT_TRIM_BIT  = 17;
  localparam int           STAT_ACT_BIT   = 18;
  localparam int           STAT_SEL_BIT   = 19;

  // ==========================================================
  // Filter depth limits and reset values
  localparam int           DEPTH_W        = 5;
  localparam int           HIST_LEN       = 32;
  localparam logic [4:0]   DEPTH_MIN      = 5'h01;
  localparam logic [4:0]   DEPTH_MAX      = 5'h1e;
  localparam logic [4:0]   DEPTH_RST      = 5'h08;
  localparam logic [1:0]   TRIM_RST       = 2'h0;
  localparam logic [2:0]   ALT_RST        = 3'h0;
  localparam logic         MAPPED_RST     = 1'b1;
  localparam logic [1:0]   FSRC_RST       = 2'h1;
  // Input span in volts that reset full scale stands for
  localparam int           FULL_SPAN_V    = 10;

  // ==========================================================
  // Setting codes
  localparam logic [1:0]   TRIM_PLAIN     = 2'h0;
  localparam logic [1:0]   TRIM_UNI       = 2'h1;
  localparam logic [1:0]   TRIM_REV       = 2'h2;
  localparam logic [1:0]   TRIM_NONE      = 2'h3;
  localparam logic [2:0]   ALT_CUR        = 3'h0;
  localparam logic [2:0]   ALT_BIP        = 3'h1;
  localparam logic [2:0]   ALT_POT_V      = 3'h2;
  localparam logic [2:0]   ALT_POT_I      = 3'h3;
  localparam logic [2:0]   ALT_POT_B      = 3'h4;
  localparam logic [1:0]   FSRC_TERM      = 2'h1;

  typedef enum logic [2:0] {SRC_V, SRC_I, SRC_B, SRC_SUM, SRC_POT} afss_src_t;

endpackage

// ==== pkg/afss_smp_if.sv ====
// Purpose: Carries one input's samples to its filter and the average back
// Assumes: All signals on the core clock
// Notes:   smp and avg are signed; unipolar inputs arrive zero-extended
`timescale 1ns/100ps
interface afss_smp_if import afss_pkg::*; #(parameter int W = 13);
  logic                valid;
  logic                clear;
  logic [DEPTH_W-1:0]  depth;
  logic signed [W-1:0] smp;
  logic signed [W-1:0] avg;
  modport src  (output valid, clear, depth, smp, input avg);
  modport filt (input valid, clear, depth, smp, output avg);
endinterface

// ==== rtl/afss_avg_filter.sv ====
// Purpose: Moving average over the last depth samples of one input
// Assumes: Depth held between 1 and 30; clear pulsed when depth changes
// Notes:   History starts at zero, so the average ramps up after clear
`timescale 1ns/100ps
module afss_avg_filter import afss_pkg::*; #(
  parameter int W    = 13,
  parameter int HIST = HIST_LEN
) (
  input  wire logic    CORE_CLK,
  input  wire logic    RST,
  afss_smp_if.filt     port
);
  localparam int AW = $clog2(HIST);
  localparam int SW = W + AW + 1;

  logic signed [W-1:0]  hist [HIST];
  logic [AW-1:0]        wptr;
  logic signed [SW-1:0] sum;

  // ==========================================================
  // Running sum: add newest, drop the one depth samples back
  wire [AW-1:0]        old_idx  = wptr - AW'(port.depth);
  wire signed [W-1:0]  old_smp  = hist[old_idx];
  wire signed [SW-1:0] next_sum = sum + SW'(port.smp) - SW'(old_smp);
  wire signed [SW-1:0] div_by   = $signed({{(SW-DEPTH_W){1'b0}}, port.depth});
  wire signed [SW-1:0] next_avg = next_sum / div_by;

  // Clear wipes history so a new depth never mixes stale terms
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      wptr     <= '0;
      sum      <= '0;
      port.avg <= '0;
      for (int k = 0; k < HIST; k++) hist[k] <= '0;
    end else if (port.clear) begin
      wptr <= '0;
      sum  <= '0;
      for (int k = 0; k < HIST; k++) hist[k] <= '0;
    end else if (port.valid) begin
      hist[wptr] <= port.smp;
      wptr       <= wptr + 1'b1;
      sum        <= next_sum;
      port.avg   <= W'(next_avg);
    end
  end

  // ==========================================================
  // Depth one passes the newest sample straight through
  property p_depth_one;
    @(posedge CORE_CLK) disable iff (RST)
    port.valid && !port.clear && port.depth == 5'h01 |=> port.avg == $past(port.smp);
  endproperty
  a_depth_one: assert property (p_depth_one) else $error("Depth one average wrong");

endmodule

// ==== rtl/afss_top.sv ====
// Purpose: Filters analog samples and selects the frequency command source
// Assumes: Sample words on the core clock; select pin asynchronous
// Notes:   Command recomputed every cycle so select changes reach the outputs on the third edge
`timescale 1ns/100ps
module afss_top import afss_pkg::*; #(
  parameter int W = 12
) (
  input  wire logic                CORE_CLK,
  input  wire logic                RST,
  input  wire logic [ADDR_W-1:0]   ADDR,
  input  wire logic [31:0]         WR_DATA,
  input  wire logic                WR_STB,
  input  wire logic                RD_STB,
  output logic      [31:0]         RD_DATA,
  input  wire logic                SAMPLE_VALID,
  input  wire logic [W-1:0]        VOLT_IN,
  input  wire logic [W-1:0]        CURRENT_IN,
  input  wire logic signed [W-1:0] BIPOLAR_VIN,
  input  wire logic [W-1:0]        KEYPAD_POT,
  input  wire logic                ANALOG_TYPE_SELECT,
  output logic      [W-1:0]        FREQ_CMD,
  output logic                     FREQ_REV,
  output logic                     TRIM_ACTIVE,
  output logic                     CMD_ACTIVE
);
  localparam int FW = W + 1;
  localparam int CW = W + 3;
  localparam logic [W-1:0]  MAX_W  = {W{1'b1}};
  localparam logic signed [CW-1:0] MAX_C = $signed({3'h0, MAX_W});

  // ==========================================================
  // Configuration registers
  logic [DEPTH_W-1:0] depth;
  logic [1:0]         trim_cfg;
  logic [2:0]         alt_cfg;
  logic               mapped;
  logic [1:0]         fsrc;
  logic [W-1:0]       fscale;
  logic               filt_clear;
  logic               sel_meta;
  logic               sel_sync;

  // Write decode and clamping
  wire                wr_cfg     = WR_STB && (ADDR == REG_CFG);
  wire                wr_fscale  = WR_STB && (ADDR == REG_FSCALE);
  wire [DEPTH_W-1:0]  wr_depth   = WR_DATA[CFG_DEPTH_LSB +: DEPTH_W];
  wire [DEPTH_W-1:0]  next_depth = (wr_depth < DEPTH_MIN) ? DEPTH_MIN :
                                   (wr_depth > DEPTH_MAX) ? DEPTH_MAX : wr_depth;
  wire [W-1:0]        wr_fs      = WR_DATA[W-1:0];
  wire [W-1:0]        next_fscale = (wr_fs == '0) ? W'(1) : wr_fs;  // Zero would divide by zero

  // Register writes; a depth change also restarts the filters
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      depth      <= DEPTH_RST;
      trim_cfg   <= TRIM_RST;
      alt_cfg    <= ALT_RST;
      mapped     <= MAPPED_RST;
      fsrc       <= FSRC_RST;
      fscale     <= MAX_W;
      filt_clear <= 1'b0;
    end else begin
      filt_clear <= wr_cfg && (next_depth != depth);
      if (wr_cfg) begin
        depth    <= next_depth;
        trim_cfg <= WR_DATA[CFG_TRIM_LSB +: 2];
        alt_cfg  <= WR_DATA[CFG_ALT_LSB +: 3];
        mapped   <= WR_DATA[CFG_MAPPED_BIT];
        fsrc     <= WR_DATA[CFG_FSRC_LSB +: 2];
      end
      if (wr_fscale) fscale <= next_fscale;
    end
  end

  property p_depth_clamp;
    @(posedge CORE_CLK) disable iff (RST)
    wr_cfg && (wr_depth > DEPTH_MAX) |=> depth == DEPTH_MAX;
  endproperty
  a_depth_clamp: assert property (p_depth_clamp) else $error("Depth not clamped to top");

  // ==========================================================
  // Select pin synchroniser, two stages before any use
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sel_meta <= 1'b0;
      sel_sync <= 1'b0;
    end else begin
      sel_meta <= ANALOG_TYPE_SELECT;
      sel_sync <= sel_meta;
    end
  end

  // ==========================================================
  // One shared-depth filter per voltage, current and bipolar input; keypad unfiltered
  afss_smp_if #(.W(FW)) if_v ();
  afss_smp_if #(.W(FW)) if_i ();
  afss_smp_if #(.W(FW)) if_b ();

  // Same depth and clear on every path keeps the inputs matched
  assign if_v.valid = SAMPLE_VALID;
  assign if_v.clear = filt_clear;
  assign if_v.depth = depth;
  assign if_v.smp   = $signed({1'b0, VOLT_IN});
  assign if_i.valid = SAMPLE_VALID;
  assign if_i.clear = filt_clear;
  assign if_i.depth = depth;
  assign if_i.smp   = $signed({1'b0, CURRENT_IN});
  assign if_b.valid = SAMPLE_VALID;
  assign if_b.clear = filt_clear;
  assign if_b.depth = depth;
  assign if_b.smp   = FW'(BIPOLAR_VIN);

  afss_avg_filter #(.W(FW)) u_filt_v (
    .CORE_CLK (CORE_CLK),
    .RST      (RST),
    .port     (if_v.filt)
  );
  afss_avg_filter #(.W(FW)) u_filt_i (
    .CORE_CLK (CORE_CLK),
    .RST      (RST),
    .port     (if_i.filt)
  );
  afss_avg_filter #(.W(FW)) u_filt_b (
    .CORE_CLK (CORE_CLK),
    .RST      (RST),
    .port     (if_b.filt)
  );

  // ==========================================================
  // Source selection; unknown alternate codes act as current
  afss_src_t map_src;
  afss_src_t unm_src;
  afss_src_t main_src;
  wire [2:0] alt_eff  = (alt_cfg > ALT_POT_B) ? ALT_CUR : alt_cfg;
  wire       alt_pot  = (alt_eff >= ALT_POT_V);
  wire       trim_on  = (trim_cfg == TRIM_UNI) || (trim_cfg == TRIM_REV);

  // Select low: voltage, or current / bipolar for keypad modes
  assign map_src = !sel_sync ?
                   ((alt_eff == ALT_POT_I) ? SRC_I :
                    (alt_eff == ALT_POT_B) ? SRC_B : SRC_V) :
                   ((alt_eff == ALT_CUR)   ? SRC_I :
                    (alt_eff == ALT_BIP)   ? SRC_B : SRC_POT);
  // Unmapped select ignores the alternate setting altogether
  assign unm_src  = (trim_cfg == TRIM_PLAIN) ? SRC_B : SRC_SUM;
  assign main_src = mapped ? map_src : unm_src;

  wire main_vi = (main_src == SRC_V) || (main_src == SRC_I);
  // Trim never applies when bipolar is itself the command
  wire trim_en = mapped ?
                 ((main_src == SRC_POT) || (main_vi && (alt_pot || trim_on))) :
                 trim_on;
  wire rev_en  = mapped ?
                 ((main_src == SRC_B) || (!alt_pot && trim_cfg == TRIM_REV)) :
                 ((trim_cfg == TRIM_PLAIN) || (trim_cfg == TRIM_REV));
  wire bip_uni = !mapped && (trim_cfg == TRIM_UNI);

  property p_plain_modes;
    @(posedge CORE_CLK) disable iff (RST)
    mapped && (trim_cfg == TRIM_PLAIN || trim_cfg == TRIM_NONE) && alt_cfg == ALT_CUR
    |-> !trim_en && !rev_en && main_src == (sel_sync ? SRC_I : SRC_V);
  endproperty
  a_plain_modes: assert property (p_plain_modes) else $error("Plain mode selection wrong");

  property p_uni_trim;
    @(posedge CORE_CLK) disable iff (RST)
    mapped && trim_cfg == TRIM_UNI && alt_cfg <= ALT_BIP
    |-> (main_vi == trim_en) && (rev_en == (main_src == SRC_B));
  endproperty
  a_uni_trim: assert property (p_uni_trim) else $error("Trim mode one selection wrong");

  property p_rev_mode;
    @(posedge CORE_CLK) disable iff (RST)
    mapped && trim_cfg == TRIM_REV && alt_cfg <= ALT_BIP |-> rev_en && (trim_en == main_vi);
  endproperty
  a_rev_mode: assert property (p_rev_mode) else $error("Reverse trim mode wrong");

  property p_keypad;
    @(posedge CORE_CLK) disable iff (RST)
    mapped && sel_sync && alt_cfg >= ALT_POT_V && alt_cfg <= ALT_POT_B
    |-> main_src == SRC_POT && trim_en && !rev_en;
  endproperty
  a_keypad: assert property (p_keypad) else $error("Keypad source not chosen");

  // Table rows spelled out so a wrong decode cannot agree with itself
  property p_unmapped;
    @(posedge CORE_CLK) disable iff (RST)
    !mapped |-> ((trim_cfg == TRIM_PLAIN) ?
                 (main_src == SRC_B && rev_en && !trim_en) :
                 (main_src == SRC_SUM && trim_en == (trim_cfg != TRIM_NONE)
                  && rev_en == (trim_cfg == TRIM_REV)));
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("Unmapped selection wrong");

  // ==========================================================
  // Command arithmetic: voltage scaled to the full-scale point
  wire [W-1:0]        v_u     = if_v.avg[W-1:0];
  wire [W-1:0]        i_u     = if_i.avg[W-1:0];
  wire [2*W-1:0]      v_prod  = v_u * MAX_W;
  wire [2*W-1:0]      v_div   = v_prod / {{W{1'b0}}, fscale};
  wire [W-1:0]        v_sc    = (v_div > {{W{1'b0}}, MAX_W}) ? MAX_W : v_div[W-1:0];
  wire signed [CW-1:0] v_s    = $signed({3'h0, v_sc});
  wire signed [CW-1:0] i_s    = $signed({3'h0, i_u});
  wire signed [CW-1:0] pot_s  = $signed({3'h0, KEYPAD_POT});
  wire signed [CW-1:0] b_s    = CW'(if_b.avg);

  property p_full_scale;
    @(posedge CORE_CLK) disable iff (RST)
    v_u >= fscale |-> v_sc == MAX_W;
  endproperty
  a_full_scale: assert property (p_full_scale) else $error("Full-scale point not maximum");

  // Main value per source; summation adds voltage and current
  wire signed [CW-1:0] main_val = (main_src == SRC_V)   ? v_s :
                                  (main_src == SRC_I)   ? i_s :
                                  (main_src == SRC_B)   ? b_s :
                                  (main_src == SRC_SUM) ? v_s + i_s : pot_s;
  // Unmapped mode 01 trim drops negative offsets rather than reversing
  wire signed [CW-1:0] trim_val = !trim_en ? '0 :
                                  (bip_uni && b_s < 0) ? '0 : b_s;
  wire signed [CW-1:0] cmd_sum  = main_val + trim_val;
  wire                 cmd_neg  = cmd_sum < 0;
  wire                 cmd_rev  = rev_en && cmd_neg;
  // Negative without reverse permission clamps to a stop
  wire signed [CW-1:0] cmd_mag  = !cmd_neg ? cmd_sum : (rev_en ? -cmd_sum : '0);
  wire [W-1:0]         cmd_sat  = (cmd_mag > MAX_C) ? MAX_W : cmd_mag[W-1:0];
  wire                 freq_on  = (fsrc == FSRC_TERM);

  property p_bip_alone;
    @(posedge CORE_CLK) disable iff (RST)
    main_src == SRC_B |-> !trim_en && trim_val == 0;
  endproperty
  a_bip_alone: assert property (p_bip_alone) else $error("Bipolar main got a trim");

  property p_unipolar;
    @(posedge CORE_CLK) disable iff (RST)
    !mapped && trim_cfg == TRIM_UNI && freq_on |=> !FREQ_REV;
  endproperty
  a_unipolar: assert property (p_unipolar) else $error("Unipolar trim gave reverse");

  // ==========================================================
  // Registered command outputs, refreshed every cycle
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      FREQ_CMD    <= '0;
      FREQ_REV    <= 1'b0;
      TRIM_ACTIVE <= 1'b0;
      CMD_ACTIVE  <= 1'b0;
    end else begin
      FREQ_CMD    <= freq_on ? cmd_sat : '0;
      FREQ_REV    <= freq_on && cmd_rev;
      TRIM_ACTIVE <= freq_on && trim_en;
      CMD_ACTIVE  <= freq_on;
    end
  end

  property p_src_gate;
    @(posedge CORE_CLK) disable iff (RST)
    !freq_on |=> FREQ_CMD == '0 && !CMD_ACTIVE && !FREQ_REV && !TRIM_ACTIVE;
  endproperty
  a_src_gate: assert property (p_src_gate) else $error("Command not gated by source");

  property p_direction;
    @(posedge CORE_CLK) disable iff (RST)
    freq_on && rev_en |=> FREQ_REV == $past(cmd_neg);
  endproperty
  a_direction: assert property (p_direction) else $error("Direction not from sign");

  property p_sel_change;
    @(posedge CORE_CLK) disable iff (RST)
    freq_on && mapped && $changed(sel_sync) && alt_cfg == ALT_POT_V |=> TRIM_ACTIVE;
  endproperty
  a_sel_change: assert property (p_sel_change) else $error("Select change not applied");

  // ==========================================================
  // Register read port, data only in the cycle after the strobe
  wire [31:0] rd_cfg  = {10'h000, fsrc, 3'h0, mapped, 1'b0, alt_cfg,
                         2'h0, trim_cfg, 3'h0, depth};
  wire [31:0] rd_stat = {12'h000, sel_sync, CMD_ACTIVE, TRIM_ACTIVE, FREQ_REV,
                         {(16-W){1'b0}}, FREQ_CMD};
  wire [31:0] rd_mux  = (ADDR == REG_CFG)    ? rd_cfg :
                        (ADDR == REG_FSCALE) ? {{(32-W){1'b0}}, fscale} :
                        (ADDR == REG_STATUS) ? rd_stat : 32'h0000_0000;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      RD_DATA <= '0;
    end else begin
      RD_DATA <= RD_STB ? rd_mux : '0;
    end
  end

endmodule

// ==== dv/afss_afe_model.sv ====
// Purpose: Front end model that converts and hands over analog samples
// Assumes: Samples launched right after a rising edge of the core clock
// Notes:   Between samples the lines carry the inverse of the last word
`timescale 1ns/100ps
module afss_afe_model #(
  parameter int W = 12
) (
  input  wire logic    clk,
  output logic         smp_valid,
  output logic [W-1:0] volt,
  output logic [W-1:0] curr,
  output logic [W-1:0] bip
);
  // ==========================================================
  // Sample handover
  initial begin
    smp_valid = 1'b0;
    volt      = '0;
    curr      = '0;
    bip       = '0;
  end

  // One-cycle valid; scrambled lines catch a stale capture
  task automatic send(input logic [W-1:0] v, input logic [W-1:0] i, input logic [W-1:0] b);
    @(posedge clk);
    smp_valid <= 1'b1;
    volt      <= v;
    curr      <= i;
    bip       <= b;
    @(posedge clk);
    smp_valid <= 1'b0;
    volt      <= ~v;
    curr      <= ~i;
    bip       <= ~b;
  endtask
endmodule

// ==== dv/tb_analog_freq_source_select.sv ====
// Purpose: Self-checking bench for the analog frequency source selector
// Assumes: Register port with one-cycle read data, samples from the model
// Notes:   Bipolar sample kept negative so reverse permission is visible
`timescale 1ns/100ps
module tb_analog_freq_source_select import afss_pkg::*;;
  // ==========================================================
  // Stimulus levels: voltage, current, bipolar, keypad
  localparam int VV = 256;
  localparam int IV = 512;
  localparam int BV = -896;
  localparam int PV = 1024;

  logic              core_clk    = 1'b0;
  logic              rst         = 1'b1;
  logic [ADDR_W-1:0] addr        = '0;
  logic [31:0]       wr_data     = '0;
  logic              wr_stb      = 1'b0;
  logic              rd_stb      = 1'b0;
  logic              sel         = 1'b0;
  logic [31:0]       rd_data;
  logic              smp_valid;
  logic [11:0]       volt;
  logic [11:0]       curr;
  logic [11:0]       bip;
  logic [11:0]       freq_cmd;
  logic              freq_rev;
  logic              trim_active;
  logic              cmd_active;
  int                num_errors  = 0;
  int                compares    = 0;

  always #10 core_clk = ~core_clk;

  afss_afe_model #(.W(12)) i_afss_afe_model (.clk(core_clk), .smp_valid(smp_valid), .volt(volt),
    .curr(curr), .bip(bip));

  afss_top #(.W(12)) i_afss_top (.CORE_CLK(core_clk), .RST(rst), .ADDR(addr), .WR_DATA(wr_data),
    .WR_STB(wr_stb), .RD_STB(rd_stb), .RD_DATA(rd_data), .SAMPLE_VALID(smp_valid), .VOLT_IN(volt),
    .CURRENT_IN(curr), .BIPOLAR_VIN(bip), .KEYPAD_POT(12'h400), .ANALOG_TYPE_SELECT(sel),
    .FREQ_CMD(freq_cmd), .FREQ_REV(freq_rev), .TRIM_ACTIVE(trim_active), .CMD_ACTIVE(cmd_active));

  // ==========================================================
  // Shared helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr    <= a;
    wr_data <= d;
    wr_stb  <= 1'b1;
    @(posedge core_clk);
    wr_stb  <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1 chk(rd_data, exp);
  endtask

  function automatic logic [31:0] cfg(input logic [4:0] dp, input logic [1:0] tm, input logic [2:0] al,
                                      input logic mp, input logic [1:0] fs);
    return {10'h000, fs, 3'h0, mp, 1'b0, al, 2'h0, tm, 3'h0, dp};
  endfunction

  // Expected {reverse, trim, command} for the fixed stimulus levels
  function automatic logic [13:0] exp_out(input logic [1:0] tm, input logic [2:0] al, input logic sl,
                                          input logic mp);
    int   m;
    logic tr;
    logic rv;
    tr = (tm == 2'h1 || tm == 2'h2);
    rv = (tm == 2'h2);
    if (!mp) begin
      rv = rv || (tm == 2'h0);
      m  = (tm == 2'h0) ? BV : VV + IV + ((tm == 2'h2) ? BV : 0);
    end else if (sl && al >= 3'h2) begin
      m  = PV + BV;
      tr = 1'b1;
      rv = 1'b0;
    end else if (al == 3'h4 || (sl && al == 3'h1)) begin
      m  = BV;
      tr = 1'b0;
      rv = 1'b1;
    end else if (al == 3'h2 || al == 3'h3) begin
      m  = ((al == 3'h2) ? VV : IV) + BV;
      tr = 1'b1;
      rv = 1'b0;
    end else begin
      m  = (sl ? IV : VV) + (tr ? BV : 0);
    end
    if (m < 0) m = rv ? -m : 0;
    else rv = 1'b0;
    return {rv, tr, m[11:0]};
  endfunction

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rd_chk(REG_CFG, 32'h00110008);
    rd_chk(REG_FSCALE, 32'h00000fff);
    wr(8'h0c, 32'hffffffff);
    rd_chk(8'h0c, 32'h00000000);
    rd_chk(REG_CFG, 32'h00110008);
  endtask

  // Depth limits, then a two-deep average ramping from zero history
  task automatic t_filter();
    wr(REG_CFG, cfg(5'h00, TRIM_NONE, ALT_CUR, 1'b1, FSRC_TERM));
    rd_chk(REG_CFG, cfg(5'h01, TRIM_NONE, ALT_CUR, 1'b1, FSRC_TERM));
    wr(REG_CFG, cfg(5'h1f, TRIM_NONE, ALT_CUR, 1'b1, FSRC_TERM));
    rd_chk(REG_CFG, cfg(5'h1e, TRIM_NONE, ALT_CUR, 1'b1, FSRC_TERM));
    wr(REG_CFG, cfg(5'h02, TRIM_NONE, ALT_CUR, 1'b1, FSRC_TERM));
    cyc(2);
    i_afss_afe_model.send(12'h100, 12'h000, 12'h000);
    cyc(3);
    chk({20'h0, freq_cmd}, 32'h00000080);
    i_afss_afe_model.send(12'h300, 12'h000, 12'h000);
    cyc(3);
    chk({20'h0, freq_cmd}, 32'h00000200);
  endtask

  // Every trim mode, alternate choice, select level and mapping
  task automatic t_table();
    logic [13:0] e;
    wr(REG_CFG, cfg(5'h01, TRIM_NONE, ALT_CUR, 1'b1, FSRC_TERM));
    cyc(2);
    i_afss_afe_model.send(12'h100, 12'h200, 12'hc80);
    for (int tm = 0; tm < 4; tm++) begin
      for (int al = 0; al < 5; al++) begin
        for (int k = 0; k < 4; k++) begin
          @(posedge core_clk);
          sel <= k[0];
          wr(REG_CFG, cfg(5'h01, tm[1:0], al[2:0], k[1], FSRC_TERM));
          cyc(4);
          e = exp_out(tm[1:0], al[2:0], k[0], k[1]);
          chk({18'h0, freq_rev, trim_active, freq_cmd}, {18'h0, e});
        end
      end
    end
  endtask

  // Select change reaches the outputs on the third edge
  task automatic t_select();
    @(posedge core_clk);
    sel <= 1'b0;
    wr(REG_CFG, cfg(5'h01, TRIM_REV, ALT_CUR, 1'b1, FSRC_TERM));
    cyc(4);
    chk({19'h0, freq_rev, freq_cmd}, 32'h00001280);
    @(posedge core_clk);
    sel <= 1'b1;
    cyc(2);
    chk({19'h0, freq_rev, freq_cmd}, 32'h00001280);
    cyc(1);
    chk({19'h0, freq_rev, freq_cmd}, 32'h00001180);
    // Undefined alternate code is stored but acts as the current choice
    wr(REG_CFG, cfg(5'h01, TRIM_NONE, 3'h7, 1'b1, FSRC_TERM));
    cyc(3);
    chk({19'h0, freq_rev, freq_cmd}, 32'h00000200);
    rd_chk(REG_CFG, cfg(5'h01, TRIM_NONE, 3'h7, 1'b1, FSRC_TERM));
  endtask

  task automatic t_fsrc();
    for (int f = 0; f < 4; f++) begin
      wr(REG_CFG, cfg(5'h01, TRIM_NONE, ALT_CUR, 1'b1, f[1:0]));
      cyc(3);
      chk({31'h0, cmd_active}, {31'h0, f == 1});
    end
  endtask

  // Half-span full scale doubles the voltage gain and saturates
  task automatic t_scale();
    wr(REG_FSCALE, 32'h00000000);
    rd_chk(REG_FSCALE, 32'h00000001);
    wr(REG_FSCALE, 32'h00000800);
    @(posedge core_clk);
    sel <= 1'b0;
    wr(REG_CFG, cfg(5'h01, TRIM_NONE, ALT_CUR, 1'b1, FSRC_TERM));
    cyc(4);
    i_afss_afe_model.send(12'h400, 12'h000, 12'h000);
    cyc(3);
    chk({20'h0, freq_cmd}, 32'h000007ff);
    i_afss_afe_model.send(12'h900, 12'h000, 12'h000);
    cyc(3);
    chk({20'h0, freq_cmd}, 32'h00000fff);
    rd_chk(REG_STATUS, 32'h00040fff);
  endtask

  // ==========================================================
  // Verdict and run control
  task automatic conclude();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Hang guard, far above the longest sequence
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    conclude();
  end

  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_filter();
    t_table();
    t_select();
    t_fsrc();
    t_scale();
    conclude();
  end
endmodule
